// [shared/keyed_watchdog_timer_regs.vh]
// Purpose: Register map, field layout and timing for the keyed watchdog
// Assumes: 32-bit APB, one register per aligned word
// Notes:   Included by every watchdog design file except the key reset delay
`ifndef KEYED_WATCHDOG_TIMER_REGS_VH
`define KEYED_WATCHDOG_TIMER_REGS_VH

// Byte offsets
`define WDT_CTRL_OFS      12'h000
`define WDT_FLAGS_OFS     12'h004
`define WDT_STATUS_OFS    12'h008
`define WDT_COUNT_OFS     12'h00C

// Control field positions
`define WDT_KEY_MSB       7
`define WDT_KEY_LSB       3
`define WDT_SEL_MSB       2
`define WDT_SEL_LSB       0

// Flag and status bit positions
`define WDT_KEY_RST_BIT   0
`define WDT_TO_BIT        0
`define WDT_PDF_BIT       1

// Reset values and key codes
`define WDT_CTRL_POR      8'h53
`define WDT_KEY_ENABLE    5'h0A
`define WDT_KEY_DISABLE   5'h15

// Timing
`define WDT_MCLK_PERIOD_NS 25
`define WDT_SW_RESET_NS    1000

`endif

// [logic/wdt_counter.v]
// Purpose: Watchdog count of low-speed oscillator edges with overflow
// Assumes: tick is a one-cycle pulse per oscillator rising edge
// Notes:   Clear has priority over counting
`timescale 1ns/1ps
`include "keyed_watchdog_timer_regs.vh"

module wdt_counter #(
    parameter CNT_W = 19
) (
    input  wire             mclk,
    input  wire             rst,
    input  wire             clk_en,
    input  wire             tick,
    input  wire             run,
    input  wire             clear,
    input  wire [2:0]       sel,
    output reg  [CNT_W-1:0] count_q,
    output reg              overflow_q
);

    // Overflow limit for each timeout select code
    function [CNT_W-1:0] limit;
        input [2:0] s;
        begin
            case (s)
                3'h0:    limit = 19'h00100;
                3'h1:    limit = 19'h00400;
                3'h2:    limit = 19'h01000;
                3'h3:    limit = 19'h04000;
                3'h4:    limit = 19'h08000;
                3'h5:    limit = 19'h10000;
                3'h6:    limit = 19'h20000;
                default: limit = 19'h40000;
            endcase
        end
    endfunction

    // Count oscillator edges, wrap to zero on overflow
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_q    <= 19'h00000;
            overflow_q <= 1'b0;
        end else if (clk_en) begin
            overflow_q <= 1'b0;
            if (clear) begin
                count_q <= 19'h00000;
            end else if (run && tick) begin
                if (count_q == limit(sel) - 19'h00001) begin
                    count_q    <= 19'h00000;
                    overflow_q <= 1'b1;
                end else begin
                    count_q <= count_q + 19'h00001;
                end
            end
        end
    end

endmodule // wdt_counter

// [logic/key_reset_delay.v]
// Purpose: Fixed delay between a key fault and the reset it causes
// Assumes: start is ignored while a delay runs
// Notes:   done is a one-cycle pulse at the end of the delay
`timescale 1ns/1ps

module key_reset_delay #(
    parameter DLY_W  = 16,
    parameter CYCLES = 40
) (
    input  wire mclk,
    input  wire rst,
    input  wire clk_en,
    input  wire start,
    output reg  busy_q,
    output reg  done_q
);

    reg [DLY_W-1:0] cnt_q;

    // Run the delay once per start
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q  <= {DLY_W{1'b0}};
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (clk_en) begin
            done_q <= 1'b0;
            if (!busy_q) begin
                if (start) begin
                    busy_q <= 1'b1;
                    cnt_q  <= {DLY_W{1'b0}};
                end
            end else if (cnt_q == CYCLES[DLY_W-1:0] - 1'b1) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule // key_reset_delay

// [logic/keyed_watchdog_timer.v]
// Purpose: Keyed watchdog timer with APB register access
// Assumes: All inputs synchronous to mclk; oscillator sampled as data
// Notes:   Reset outputs are one-cycle pulses for the system reset logic
`timescale 1ns/1ps
`include "keyed_watchdog_timer_regs.vh"

// Notes on behaviour
// - Counter advances only on oscillator edges
// - Select field picks 2^8 to 2^18 period
// - Key 10101B disables counting
// - Key 01010B enables counting
// - Other key values reset after delay
// - Key fault sets key reset flag
// - Flag cleared only by software zero
// - Power-on key 01010B, select 011
// - Running overflow resets device, sets timeout
// - Sleep overflow sets flags, resets PC/SP
// - Clear instruction clears counter
// - Halt instruction clears counter
// - Selected reset pin low clears counter
// - Key fault reset clears counter
// - Flag register bits 7..4 read zero
// - After halt, count resumes only if enabled
// - Power-down flag: halt sets, clear clears
module keyed_watchdog_timer #(
    parameter SW_RESET_NS = `WDT_SW_RESET_NS,
    parameter CNT_W       = 19,
    parameter DLY_W       = 16
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        clk_en,
    input  wire        low_speed_osc_clock,
    input  wire        clear_watchdog_instruction,
    input  wire        halt_instruction,
    input  wire        sleep_or_idle,
    input  wire        reset_pin_n,
    input  wire        reset_pin_selected,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    output reg         device_reset_q,
    output reg         pc_sp_reset_q,
    output reg         timeout_status_flag,
    output reg         power_down_flag,
    output wire        watchdog_enabled
);

    // Delay in mclk cycles, rounded up, at least one
    localparam SRST_RAW = (SW_RESET_NS + `WDT_MCLK_PERIOD_NS - 1)
                          / `WDT_MCLK_PERIOD_NS;
    localparam SRST_CYC = (SRST_RAW < 1) ? 1 : SRST_RAW;

    reg  [7:0]       watchdog_control_q;
    reg              watchdog_key_reset_flag;
    reg              osc_q;
    wire             osc_tick;
    wire [4:0]       watchdog_key_field;
    wire [2:0]       timeout_select;
    wire             key_ok;
    wire             key_off;
    wire             run;
    wire             cnt_clear;
    wire             pin_clear;
    wire [CNT_W-1:0] count;
    wire             overflow;
    wire             dly_busy;
    wire             dly_done;
    wire             dly_start;
    wire             setup;
    wire             access;
    wire             wr;
    wire             addr_ok;

    // True for the two legal key codes
    function key_legal;
        input [4:0] k;
        begin
            key_legal = (k == `WDT_KEY_ENABLE) ||
                        (k == `WDT_KEY_DISABLE);
        end
    endfunction

    // True for a mapped register offset
    function addr_mapped;
        input [11:0] a;
        begin
            addr_mapped = (a == `WDT_CTRL_OFS)   ||
                          (a == `WDT_FLAGS_OFS)  ||
                          (a == `WDT_STATUS_OFS) ||
                          (a == `WDT_COUNT_OFS);
        end
    endfunction

    // Control fields
    assign watchdog_key_field = watchdog_control_q[`WDT_KEY_MSB:`WDT_KEY_LSB];
    assign timeout_select     = watchdog_control_q[`WDT_SEL_MSB:`WDT_SEL_LSB];
    assign key_ok             = key_legal(watchdog_key_field);
    assign key_off            = (watchdog_key_field == `WDT_KEY_DISABLE);

    // Enable only on the enable key
    assign run              = (watchdog_key_field == `WDT_KEY_ENABLE);
    assign watchdog_enabled = run;

    // Oscillator rising edge detect
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            osc_q <= 1'b0;
        end else if (clk_en) begin
            osc_q <= low_speed_osc_clock;
        end
    end

    assign osc_tick = low_speed_osc_clock & ~osc_q;

    // Counter clear sources
    assign pin_clear = reset_pin_selected & ~reset_pin_n;
    assign cnt_clear = clear_watchdog_instruction |
                       halt_instruction |
                       pin_clear |
                       dly_done;

    // Watchdog count; disabled key holds it stopped
    wdt_counter #(
        .CNT_W      (CNT_W)
    ) u_counter (
        .mclk       (mclk),
        .rst        (rst),
        .clk_en     (clk_en),
        .tick       (osc_tick),
        .run        (run & ~key_off),
        .clear      (cnt_clear),
        .sel        (timeout_select),
        .count_q    (count),
        .overflow_q (overflow)
    );

    // Start the delay on any illegal key, written or corrupted
    assign dly_start = ~key_ok & ~dly_busy & ~dly_done;

    key_reset_delay #(
        .DLY_W  (DLY_W),
        .CYCLES (SRST_CYC)
    ) u_delay (
        .mclk   (mclk),
        .rst    (rst),
        .clk_en (clk_en),
        .start  (dly_start),
        .busy_q (dly_busy),
        .done_q (dly_done)
    );

    // APB phases
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign addr_ok = addr_mapped(paddr);
    assign wr      = access & pwrite & addr_ok;
    assign pready  = 1'b1;
    assign pslverr = access & ~addr_ok;

    // Control register; fault reset restores power-on value
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            watchdog_control_q <= `WDT_CTRL_POR;
        end else if (clk_en) begin
            if (dly_done) begin
                watchdog_control_q <= `WDT_CTRL_POR;
            end else if (wr && paddr == `WDT_CTRL_OFS && pstrb[0]) begin
                watchdog_control_q <= pwdata[7:0];
            end
        end
    end

    // Key reset flag; hardware set wins over software clear
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            watchdog_key_reset_flag <= 1'b0;
        end else if (clk_en) begin
            if (dly_done) begin
                watchdog_key_reset_flag <= 1'b1;
            end else if (wr && paddr == `WDT_FLAGS_OFS && pstrb[0] &&
                         !pwdata[`WDT_KEY_RST_BIT]) begin
                watchdog_key_reset_flag <= 1'b0;
            end
        end
    end

    // Timeout flag: set by overflow, cleared by halt or clear
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            timeout_status_flag <= 1'b0;
        end else if (clk_en) begin
            if (overflow) begin
                timeout_status_flag <= 1'b1;
            end else if (halt_instruction || clear_watchdog_instruction) begin
                timeout_status_flag <= 1'b0;
            end
        end
    end

    // Power-down flag: halt or sleep overflow set, clear instruction clears
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            power_down_flag <= 1'b0;
        end else if (clk_en) begin
            if (halt_instruction || (overflow && sleep_or_idle)) begin
                power_down_flag <= 1'b1;
            end else if (clear_watchdog_instruction) begin
                power_down_flag <= 1'b0;
            end
        end
    end

    // Reset pulses: full reset when running, PC/SP only when asleep
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            device_reset_q <= 1'b0;
            pc_sp_reset_q  <= 1'b0;
        end else if (clk_en) begin
            device_reset_q <= dly_done |
                              (overflow & ~sleep_or_idle);
            pc_sp_reset_q  <= overflow & sleep_or_idle;
        end
    end

    // Read data captured in the setup phase
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (clk_en) begin
            if (setup && !pwrite) begin
                case (paddr)
                    `WDT_CTRL_OFS: begin
                        prdata <= {24'h000000, watchdog_control_q};
                    end
                    `WDT_FLAGS_OFS: begin
                        prdata <= {31'h00000000, watchdog_key_reset_flag};
                    end
                    `WDT_STATUS_OFS: begin
                        prdata <= {30'h00000000, power_down_flag,
                                   timeout_status_flag};
                    end
                    `WDT_COUNT_OFS: begin
                        prdata <= {{(32-CNT_W){1'b0}}, count};
                    end
                    default: begin
                        prdata <= 32'h00000000;
                    end
                endcase
            end
        end
    end

endmodule // keyed_watchdog_timer

// [verification/wdt_monitor.sv]
// Purpose: Port-level checks of the keyed watchdog
// Assumes: Single mclk domain, rst async active high
// Notes:   Bound into every keyed_watchdog_timer instance
`timescale 1ns/1ps
`include "keyed_watchdog_timer_regs.vh"

module wdt_monitor (
    input wire        mclk,
    input wire        rst,
    input wire        clk_en,
    input wire        clear_watchdog_instruction,
    input wire        halt_instruction,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        device_reset_q,
    input wire        pc_sp_reset_q,
    input wire        timeout_status_flag,
    input wire        power_down_flag,
    input wire        watchdog_enabled
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // Overflow flag, reset pulses, power-down tracking and flag register reads
    AST_TO_WITH_PULSE: assert property ($rose(timeout_status_flag) |-> device_reset_q || pc_sp_reset_q)
        else $error("timeout flag rose without a reset pulse");
    AST_SLEEP_FLAGS: assert property (pc_sp_reset_q |-> timeout_status_flag && power_down_flag)
        else $error("sleep overflow without both flags");
    AST_PULSE_ONE: assert property ((device_reset_q || pc_sp_reset_q) |=> !(device_reset_q || pc_sp_reset_q))
        else $error("reset pulse longer than one cycle");
    AST_HALT_PD: assert property (halt_instruction && clk_en |=> power_down_flag)
        else $error("halt did not set power-down flag");
    AST_CLR_TO: assert property (clear_watchdog_instruction && clk_en && !halt_instruction
        |=> !timeout_status_flag || device_reset_q || pc_sp_reset_q)
        else $error("clear left timeout flag set");
    AST_OFF_QUIET: assert property (!watchdog_enabled ##1 !watchdog_enabled |-> !pc_sp_reset_q)
        else $error("overflow while disabled");
    AST_CLR_RESTART: assert property (clear_watchdog_instruction && clk_en |-> ##2 (!pc_sp_reset_q) [*3])
        else $error("overflow right after clear");
    AST_FLAGS_HIGH_ZERO: assert property (psel && !penable && !pwrite && clk_en && paddr == `WDT_FLAGS_OFS
        |=> prdata[31:1] == 31'h0)
        else $error("flag register upper bits not zero");
endmodule // wdt_monitor

bind keyed_watchdog_timer wdt_monitor u_mon (.mclk(mclk), .rst(rst), .clk_en(clk_en),
    .clear_watchdog_instruction(clear_watchdog_instruction), .halt_instruction(halt_instruction),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .device_reset_q(device_reset_q), .pc_sp_reset_q(pc_sp_reset_q), .timeout_status_flag(timeout_status_flag),
    .power_down_flag(power_down_flag), .watchdog_enabled(watchdog_enabled));

// [verification/testbench.sv]
// Purpose: Self-checking bench for the keyed watchdog
// Assumes: Zero-wait APB, oscillator toggled every mclk
// Notes:   Timeout selects above 011 left out for run length
`timescale 1ns/1ps
`include "keyed_watchdog_timer_regs.vh"

module testbench;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        osc = 1'b0;
    logic        osc_run = 1'b0;
    logic        clr_i = 1'b0;
    logic        halt_i = 1'b0;
    logic        sleep = 1'b0;
    logic        pin_n = 1'b1;
    logic        pin_sel = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire         pready, pslverr, dev_rst, pcsp_rst, to_flag, pd_flag, wd_en;
    wire  [31:0] prdata;
    logic [31:0] rd;
    logic [31:0] cnt0;
    logic        err;
    int          mismatches = 0;
    int          total_checks = 0;
    int          n;
    int          k;

    // Clock and oscillator stimulus
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) osc <= osc_run ? ~osc : 1'b0;

    keyed_watchdog_timer dut (.mclk(mclk), .rst(rst), .clk_en(ce), .low_speed_osc_clock(osc),
        .clear_watchdog_instruction(clr_i), .halt_instruction(halt_i), .sleep_or_idle(sleep),
        .reset_pin_n(pin_n), .reset_pin_selected(pin_sel), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .device_reset_q(dev_rst), .pc_sp_reset_q(pcsp_rst),
        .timeout_status_flag(to_flag), .power_down_flag(pd_flag), .watchdog_enabled(wd_en));

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // APB transfer, waits for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge mclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic instr(input bit h);
        @(posedge mclk);
        if (h) halt_i <= 1'b1;
        else clr_i <= 1'b1;
        @(posedge mclk);
        halt_i <= 1'b0;
        clr_i <= 1'b0;
    endtask

    task automatic wait_rst(input int max);
        n = 0;
        while (!(dev_rst === 1'b1 || pcsp_rst === 1'b1) && n < max) begin
            @(negedge mclk);
            n++;
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        apb(0, `WDT_CTRL_OFS, 0); chk("ctrl_por", rd, 32'h53);
        apb(0, `WDT_FLAGS_OFS, 0); chk("flags_por", rd, 32'h0);
        apb(0, 12'h010, 0); chk("unmapped_err", {31'h0, err}, 32'h1);
        $display("test reset done");
        osc_run <= 1'b1;
        for (k = 0; k < 4; k++) begin
            apb(1, `WDT_CTRL_OFS, {24'h0, `WDT_KEY_ENABLE, k[2:0]});
            instr(0);
            wait_rst(40000);
            chk("ovf_time", {31'h0, n >= (2 << (8 + 2 * k)) - 2 && n <= (2 << (8 + 2 * k)) + 4}, 1);
            chk("ovf_dev_rst", {31'h0, dev_rst}, 32'h1);
            apb(0, `WDT_STATUS_OFS, 0); chk("ovf_status", rd, 32'h1);
        end
        $display("test periods done");
        sleep <= 1'b1;
        apb(1, `WDT_CTRL_OFS, 32'h50);
        instr(1);
        apb(0, `WDT_STATUS_OFS, 0); chk("halt_status", rd, 32'h2);
        wait_rst(2000);
        chk("sleep_pcsp", {30'h0, pcsp_rst, dev_rst}, 32'h2);
        apb(0, `WDT_STATUS_OFS, 0); chk("sleep_status", rd, 32'h3);
        instr(0);
        apb(0, `WDT_STATUS_OFS, 0); chk("clr_status", rd, 32'h0);
        sleep <= 1'b0;
        $display("test sleep done");
        apb(1, `WDT_CTRL_OFS, 32'hA8);
        apb(0, `WDT_COUNT_OFS, 0);
        cnt0 = rd;
        chk("wd_off", {31'h0, wd_en}, 32'h0);
        wait_rst(700); chk("off_quiet", n, 700);
        apb(0, `WDT_COUNT_OFS, 0); chk("off_hold", rd, cnt0);
        apb(1, `WDT_CTRL_OFS, 32'h50);
        pin_sel <= 1'b1;
        pin_n <= 1'b0;
        wait_rst(700); chk("pin_quiet", n, 700);
        apb(0, `WDT_COUNT_OFS, 0); chk("pin_count", rd, 32'h0);
        pin_n <= 1'b1;
        $display("test clear sources done");
        apb(1, `WDT_CTRL_OFS, 32'h03);
        wait_rst(100);
        k = `WDT_SW_RESET_NS / `WDT_MCLK_PERIOD_NS;
        chk("fault_delay", {31'h0, dev_rst === 1'b1 && n >= k && n <= k + 4}, 1);
        apb(0, `WDT_CTRL_OFS, 0); chk("fault_ctrl", rd, 32'h53);
        apb(0, `WDT_FLAGS_OFS, 0); chk("fault_flag", rd, 32'h1);
        apb(1, `WDT_FLAGS_OFS, 32'hFF);
        apb(0, `WDT_FLAGS_OFS, 0); chk("flag_keep", rd, 32'h1);
        ce <= 1'b0;
        apb(1, `WDT_FLAGS_OFS, 32'h0);
        ce <= 1'b1;
        apb(0, `WDT_FLAGS_OFS, 0); chk("freeze_flag", rd, 32'h1);
        apb(1, `WDT_FLAGS_OFS, 32'h0);
        apb(0, `WDT_FLAGS_OFS, 0); chk("flag_clr", rd, 32'h0);
        $display("test key fault done");
        finish_test();
    end

    // Hang guard
    initial begin
        #2000000;
        mismatches++;
        finish_test();
    end
endmodule // testbench
